/* File: hdl/ufc_pkg.sv */
// ufc_pkg: constants, register map and types shared by the dual serial port.
// assumes a 40 MHz system clock and a 32-bit APB register bus.
package ufc_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MAX_BAUD = 1_000_000;
  // least divisor: one bit time at the fastest allowed rate
  localparam int unsigned MIN_DIV = CLK_HZ / MAX_BAUD;
  localparam logic [15:0] DIV_RST = 16'h015B; // 347 cycles, about 115200 baud
  localparam int unsigned NPORT = 2;
  // register byte offsets, port 1 at PORT_STRIDE above port 0
  localparam logic [11:0] PORT_STRIDE = 12'h010;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_BAUD = 4'h4;
  localparam logic [3:0] OFF_TXD = 4'h8;
  localparam logic [3:0] OFF_RXD = 4'hC;
  // control field positions
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_PAR = 1;
  localparam int unsigned CTRL_ODD = 2;
  localparam int unsigned CTRL_STOP2 = 3;
  localparam int unsigned CTRL_HOLD = 4;
  localparam logic [4:0] CTRL_RST = 5'h00;
  // status field positions in the rx data register
  localparam int unsigned ST_RXV = 8;
  localparam int unsigned ST_PERR = 9;
  localparam int unsigned ST_FERR = 10;
  localparam int unsigned ST_OVR = 11;
  localparam int unsigned ST_TXBUSY = 12;
  localparam int unsigned ST_CTS = 13;
  typedef struct packed {
    logic hold;
    logic stop2;
    logic odd;
    logic par;
    logic en;
  } ufc_ctrl_t;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufc_tx_st_t;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufc_rx_st_t;
endpackage : ufc_pkg

/* File: hdl/ufc_top.sv */
// ufc_top: two independent full-duplex serial ports with rts/cts handshake, on APB.
// assumes pins are already synchronous to sys_clk; pull resistors live in the pad ring.
// Operation
// - full-duplex async transmit and receive, up to one megabit per second.
// - optional ninth parity bit generated on transmit, checked on receive.
// - rts is a device output, cts a device input, both active low.
// - both data lines rest high when no character is sent.
// - transmit pin is an output driven high until transmission begins.
// - receive pin is an input with pull-up; open line reads idle.
// - rts pin is an output driven low by default, ready to receive.
// - cts pin is an input with pull-down; open line reads asserted.
// - two independent port instances, each with own tx, rx, handshake.
// - framing and handshake interoperate with a conventional PC serial controller.
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module ufc_top (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] uart_tx,
  input wire logic [1:0] uart_rx,
  output logic [1:0] uart_rts_n,
  input wire logic [1:0] uart_cts_n,
  output logic [1:0] rx_pull_up,
  output logic [1:0] cts_pull_down
);
  localparam int unsigned NP = ufc_pkg::NPORT;

  // parity of a byte, flipped for odd parity
  function automatic logic par_of(input logic [7:0] d, input logic odd);
    par_of = (^d) ^ odd;
  endfunction : par_of

  // register access decode
  logic acc;
  logic [NP-1:0] sel;
  logic [3:0] roff;
  logic map_ok;
  assign acc = psel & penable & ~pready;
  assign roff = paddr[3:0];
  assign map_ok = (paddr[11:5] == 7'h00) & (paddr[1:0] == 2'b00);
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      sel[p] = map_ok & (paddr[4] == p[0]);
    end
  end

  ufc_pkg::ufc_ctrl_t ctrl_q [NP];
  logic [15:0] div_q [NP];
  logic [7:0] txbuf_q [NP];
  logic [NP-1:0] txfull_q;
  logic [7:0] rxbuf_q [NP];
  logic [NP-1:0] rxv_q, perr_q, ferr_q, ovr_q;
  ufc_pkg::ufc_tx_st_t tx_st_q [NP];
  ufc_pkg::ufc_rx_st_t rx_st_q [NP];
  logic [15:0] tx_cnt_q [NP];
  logic [15:0] rx_cnt_q [NP];
  logic [2:0] tx_bit_q [NP];
  logic [2:0] rx_bit_q [NP];
  logic [7:0] tx_sh_q [NP];
  logic [7:0] rx_sh_q [NP];
  logic [NP-1:0] tx_stop2_q, rx_ack;
  logic [NP-1:0] tx_take;

  // apb slave: one wait state, pready registered, unmapped address errors
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc;
      pslverr <= acc & ~map_ok;
      prdata <= 32'h0000_0000;
      if (acc && !pwrite) begin
        for (int p = 0; p < NP; p++) begin
          if (sel[p]) begin
            unique case (roff)
              ufc_pkg::OFF_CTRL: prdata <= {27'h0000000, ctrl_q[p]};
              ufc_pkg::OFF_BAUD: prdata <= {16'h0000, div_q[p]};
              ufc_pkg::OFF_TXD: prdata <= {23'h000000, txfull_q[p], txbuf_q[p]};
              default: prdata <= {18'h00000, ~uart_cts_n[p], tx_st_q[p] != ufc_pkg::TX_IDLE,
                ovr_q[p], ferr_q[p], perr_q[p], rxv_q[p], rxbuf_q[p]};
            endcase
          end
        end
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        ctrl_q[p] <= ufc_pkg::CTRL_RST;
        div_q[p] <= ufc_pkg::DIV_RST;
      end else if (acc && pwrite && sel[p]) begin
        if (roff == ufc_pkg::OFF_CTRL) ctrl_q[p] <= pwdata[4:0];
        // divisor clamped so the bit rate never exceeds the top rate
        if (roff == ufc_pkg::OFF_BAUD) begin
          div_q[p] <= (pwdata[15:0] < 16'(ufc_pkg::MIN_DIV)) ?
            16'(ufc_pkg::MIN_DIV) : pwdata[15:0];
        end
      end
    end
  end

  // transmit holding register: write fills, transmitter start empties
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        txfull_q[p] <= 1'b0;
        txbuf_q[p] <= 8'h00;
      end else if (acc && pwrite && sel[p] && roff == ufc_pkg::OFF_TXD && !txfull_q[p]) begin
        txfull_q[p] <= 1'b1;
        txbuf_q[p] <= pwdata[7:0];
      end else if (tx_take[p]) begin
        txfull_q[p] <= 1'b0;
      end
    end
  end

  // a new character starts only with cts asserted (low)
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      tx_take[p] = (tx_st_q[p] == ufc_pkg::TX_IDLE) & txfull_q[p] & ctrl_q[p].en
        & ~uart_cts_n[p];
    end
  end

  // transmitter; line idles high from reset on
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        tx_st_q[p] <= ufc_pkg::TX_IDLE;
        uart_tx[p] <= 1'b1;
        tx_cnt_q[p] <= 16'h0000;
        tx_bit_q[p] <= 3'h0;
        tx_sh_q[p] <= 8'h00;
        tx_stop2_q[p] <= 1'b0;
      end else begin
        tx_cnt_q[p] <= (tx_cnt_q[p] == 16'h0000) ? 16'h0000 : tx_cnt_q[p] - 16'h0001;
        unique case (tx_st_q[p])
          ufc_pkg::TX_IDLE: begin
            uart_tx[p] <= 1'b1;
            if (tx_take[p]) begin
              tx_st_q[p] <= ufc_pkg::TX_START;
              uart_tx[p] <= 1'b0;
              tx_sh_q[p] <= txbuf_q[p];
              tx_cnt_q[p] <= div_q[p] - 16'h0001;
              tx_stop2_q[p] <= ctrl_q[p].stop2;
            end
          end
          ufc_pkg::TX_START: if (tx_cnt_q[p] == 16'h0000) begin
            tx_st_q[p] <= ufc_pkg::TX_DATA;
            uart_tx[p] <= tx_sh_q[p][0];
            tx_bit_q[p] <= 3'h0;
            tx_cnt_q[p] <= div_q[p] - 16'h0001;
          end
          ufc_pkg::TX_DATA: if (tx_cnt_q[p] == 16'h0000) begin
            tx_cnt_q[p] <= div_q[p] - 16'h0001;
            if (tx_bit_q[p] == 3'h7) begin
              if (ctrl_q[p].par) begin
                tx_st_q[p] <= ufc_pkg::TX_PAR;
                uart_tx[p] <= par_of(tx_sh_q[p], ctrl_q[p].odd);
              end else begin
                tx_st_q[p] <= ufc_pkg::TX_STOP;
                uart_tx[p] <= 1'b1;
              end
            end else begin
              tx_bit_q[p] <= tx_bit_q[p] + 3'h1;
              uart_tx[p] <= tx_sh_q[p][tx_bit_q[p] + 3'h1];
            end
          end
          ufc_pkg::TX_PAR: if (tx_cnt_q[p] == 16'h0000) begin
            tx_st_q[p] <= ufc_pkg::TX_STOP;
            uart_tx[p] <= 1'b1;
            tx_cnt_q[p] <= div_q[p] - 16'h0001;
          end
          ufc_pkg::TX_STOP: if (tx_cnt_q[p] == 16'h0000) begin
            if (tx_stop2_q[p]) begin
              tx_stop2_q[p] <= 1'b0;
              tx_cnt_q[p] <= div_q[p] - 16'h0001;
            end else begin
              tx_st_q[p] <= ufc_pkg::TX_IDLE;
            end
          end
          default: tx_st_q[p] <= ufc_pkg::TX_IDLE;
        endcase
      end
    end
  end

  // receiver: start confirmed at mid-bit, every bit sampled mid-bit
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        rx_st_q[p] <= ufc_pkg::RX_IDLE;
        rx_cnt_q[p] <= 16'h0000;
        rx_bit_q[p] <= 3'h0;
        rx_sh_q[p] <= 8'h00;
      end else begin
        rx_cnt_q[p] <= (rx_cnt_q[p] == 16'h0000) ? 16'h0000 : rx_cnt_q[p] - 16'h0001;
        unique case (rx_st_q[p])
          ufc_pkg::RX_IDLE: if (ctrl_q[p].en && !uart_rx[p]) begin
            rx_st_q[p] <= ufc_pkg::RX_START;
            rx_cnt_q[p] <= {1'b0, div_q[p][15:1]};
          end
          ufc_pkg::RX_START: if (rx_cnt_q[p] == 16'h0000) begin
            // a glitch shorter than half a bit is not a start
            rx_st_q[p] <= uart_rx[p] ? ufc_pkg::RX_IDLE : ufc_pkg::RX_DATA;
            rx_bit_q[p] <= 3'h0;
            rx_cnt_q[p] <= div_q[p] - 16'h0001;
          end
          ufc_pkg::RX_DATA: if (rx_cnt_q[p] == 16'h0000) begin
            rx_sh_q[p] <= {uart_rx[p], rx_sh_q[p][7:1]};
            rx_bit_q[p] <= rx_bit_q[p] + 3'h1;
            rx_cnt_q[p] <= div_q[p] - 16'h0001;
            if (rx_bit_q[p] == 3'h7) begin
              rx_st_q[p] <= ctrl_q[p].par ? ufc_pkg::RX_PAR : ufc_pkg::RX_STOP;
            end
          end
          ufc_pkg::RX_PAR: if (rx_cnt_q[p] == 16'h0000) begin
            rx_st_q[p] <= ufc_pkg::RX_STOP;
            rx_cnt_q[p] <= div_q[p] - 16'h0001;
          end
          ufc_pkg::RX_STOP: if (rx_cnt_q[p] == 16'h0000) begin
            rx_st_q[p] <= ufc_pkg::RX_IDLE;
          end
          default: rx_st_q[p] <= ufc_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // software read of the rx data register consumes the character
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      rx_ack[p] = acc & ~pwrite & sel[p] & (roff == ufc_pkg::OFF_RXD);
    end
  end

  // receive holding register and sticky error flags; a new event beats the clear
  logic [NP-1:0] par_bad_q;
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        rxbuf_q[p] <= 8'h00;
        rxv_q[p] <= 1'b0;
        perr_q[p] <= 1'b0;
        ferr_q[p] <= 1'b0;
        ovr_q[p] <= 1'b0;
        par_bad_q[p] <= 1'b0;
      end else begin
        if (rx_ack[p]) begin
          rxv_q[p] <= 1'b0;
          perr_q[p] <= 1'b0;
          ferr_q[p] <= 1'b0;
          ovr_q[p] <= 1'b0;
        end
        if (rx_st_q[p] == ufc_pkg::RX_START) par_bad_q[p] <= 1'b0;
        if (rx_st_q[p] == ufc_pkg::RX_PAR && rx_cnt_q[p] == 16'h0000) begin
          par_bad_q[p] <= uart_rx[p] != par_of(rx_sh_q[p], ctrl_q[p].odd);
        end
        if (rx_st_q[p] == ufc_pkg::RX_STOP && rx_cnt_q[p] == 16'h0000) begin
          rxbuf_q[p] <= rx_sh_q[p];
          rxv_q[p] <= 1'b1;
          if (par_bad_q[p] && ctrl_q[p].par) perr_q[p] <= 1'b1;
          if (!uart_rx[p]) ferr_q[p] <= 1'b1;
          if (rxv_q[p] && !rx_ack[p]) ovr_q[p] <= 1'b1;
        end
      end
    end
  end

  // rts low (ready) by default; raised while a character waits unread or on hold
  always_ff @(posedge sys_clk) begin
    for (int p = 0; p < NP; p++) begin
      if (reset) begin
        uart_rts_n[p] <= 1'b0;
        rx_pull_up[p] <= 1'b1;
        cts_pull_down[p] <= 1'b1;
      end else begin
        // peer is expected to pause within a character of rts rising
        uart_rts_n[p] <= ctrl_q[p].hold | (rxv_q[p] & ~rx_ack[p]);
        rx_pull_up[p] <= 1'b1;
        cts_pull_down[p] <= 1'b1;
      end
    end
  end
endmodule : ufc_top

/* File: verification/ufc_top_monitor.sv */
// ufc_top_monitor: port assertions for the dual serial port.
// assumes one clock domain; bound into every ufc_top.
`timescale 1ns/1ps
module ufc_top_monitor (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] uart_tx,
  input wire logic [1:0] uart_rx,
  input wire logic [1:0] uart_rts_n,
  input wire logic [1:0] uart_cts_n,
  input wire logic [1:0] rx_pull_up,
  input wire logic [1:0] cts_pull_down
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic tx_q;
  logic [11:0] run_q; // cycles tx0 held its level, saturating
  always_ff @(posedge sys_clk) tx_q <= uart_tx[0];
  always_ff @(posedge sys_clk) begin
    if (reset || uart_tx[0] != tx_q) run_q <= 12'h000;
    else if (run_q != 12'hFFF) run_q <= run_q + 12'h001;
  end
  sequence acc_s; psel && penable && !pready; endsequence
  sequence stray_s; acc_s ##0 (paddr[11:5] != 7'h00 || paddr[1:0] != 2'h0); endsequence
  one_wait_a: assert property (acc_s |=> pready) else $error("late answer");
  ready_pulse_a: assert property (pready |=> !pready) else $error("long pready");
  err_timing_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  stray_refused_a: assert property (stray_s |=> pslverr) else $error("stray accepted");
  pulls_on_a: assert property (rx_pull_up == 2'h3 && cts_pull_down == 2'h3)
    else $error("pull off");
  idle_out_a: assert property ($fell(reset) |-> uart_tx == 2'h3 && uart_rts_n == 2'h0)
    else $error("bad idle");
  bit_time_a: assert property (uart_tx[0] != tx_q |-> run_q >= ufc_pkg::MIN_DIV - 1)
    else $error("short bit");
  // a long high run ends only in a start bit, never inside a frame at the bench rates
  cts_block_a: assert property ($fell(uart_tx[0]) && run_q > 12'h3E8
    |-> !($past(uart_cts_n[0]) && $past(uart_cts_n[0], 2) && $past(uart_cts_n[0], 3)))
    else $error("start while blocked");
  rts_stop_a: assert property ($rose(uart_rts_n[1]) |-> uart_rx[1])
    else $error("rts off mid bit");
endmodule : ufc_top_monitor
bind ufc_top ufc_top_monitor ufc_top_monitor_i (.sys_clk, .reset, .paddr, .psel, .penable,
  .pready, .pslverr, .uart_tx, .uart_rx, .uart_rts_n, .uart_cts_n, .rx_pull_up, .cts_pull_down);

/* File: verification/ufc_peer.sv */
// ufc_peer: far-end host sending characters into one receive line.
// assumes calls start right after a clock edge; bit time in clocks.
`timescale 1ns/1ps
module ufc_peer (
  input wire logic sys_clk,
  input wire logic rts_n,
  output logic line
);
  initial line = 1'b1;
  // par: 0 none, 1 even, 2 odd; flip spoils parity, pushy ignores rts
  task automatic send(input logic [7:0] b, input int par, input bit flip, input bit pushy,
    input int bt);
    logic [10:0] f;
    f = {2'h3, b, 1'b0};
    if (par != 0) f[9] = ^b ^ (par == 2) ^ flip;
    while (rts_n && !pushy) @(posedge sys_clk);
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (bt) @(posedge sys_clk);
    end
  endtask : send
endmodule : ufc_peer

/* File: verification/test_uart_with_flow_control.sv */
// test_uart_with_flow_control: self-checking bench for the dual serial port.
// assumes 40 MHz; peer feeds port 1 rx, port 1 tx loops into port 0 rx.
`timescale 1ns/1ps
module test_uart_with_flow_control;
  localparam int BT = ufc_pkg::MIN_DIV;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, peer_line;
  logic [11:0] paddr;
  logic [11:0] f;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [7:0] b;
  logic [1:0] uart_tx, uart_rts_n, cts_n;
  logic [4:0] modes [4] = '{5'h01, 5'h03, 5'h07, 5'h09};
  int fails, comparisons;
  ufc_top ufc_top_i (.sys_clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .uart_tx, .uart_rx({peer_line, uart_tx[1]}), .uart_rts_n,
    .uart_cts_n(cts_n), .rx_pull_up(), .cts_pull_down());
  ufc_peer ufc_peer_i (.sys_clk, .rts_n(uart_rts_n[1]), .line(peer_line));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [11:0] frame(input logic [7:0] v, input logic [4:0] c);
    if (c[ufc_pkg::CTRL_PAR]) return {2'h3, ^v ^ c[ufc_pkg::CTRL_ODD], v, 1'b0};
    return {3'h7, v, 1'b0};
  endfunction : frame
  task automatic tally_and_finish;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no cycle count is assumed here; the watchdog ends a hung wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    check({30'h0, pready, pslverr}, {30'h0, 1'b1, e});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // samples twelve bit times of port 0 from mid start bit
  task automatic grab;
    int t;
    t = 0;
    while (uart_tx[0] !== 1'b0 && t < 3000) begin
      @(posedge sys_clk);
      t++;
    end
    repeat (BT / 2) @(posedge sys_clk);
    for (int i = 0; i < 12; i++) begin
      f[i] = uart_tx[0];
      repeat (BT) @(posedge sys_clk);
    end
  endtask : grab
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    tally_and_finish;
  end
  initial begin
    seed = 32'h0000051F;
    fails = 0;
    comparisons = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cts_n = 2'h0;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    check({28'h0, uart_tx, uart_rts_n}, 32'hC);
    apb(12'h004, 1'b0, 32'h0, 1'b0);
    check(rd, {16'h0, ufc_pkg::DIV_RST});
    apb(12'h020, 1'b1, 32'hFFFFFFFF, 1'b1);
    apb(12'h006, 1'b0, 32'h0, 1'b1);
    check(rd, 32'h0);
    apb(12'h004, 1'b1, 32'h5, 1'b0);
    apb(12'h014, 1'b1, 32'h5, 1'b0);
    apb(12'h004, 1'b0, 32'h0, 1'b0);
    check(rd, BT);
    cts_n[0] <= 1'b1;
    apb(12'h000, 1'b1, 32'h1, 1'b0);
    apb(12'h008, 1'b1, 32'h5A, 1'b0);
    apb(12'h008, 1'b1, 32'hA5, 1'b0);
    apb(12'h008, 1'b0, 32'h0, 1'b0);
    check(rd, 32'h15A);
    repeat (1100) @(posedge sys_clk);
    check({31'h0, uart_tx[0]}, 32'h1);
    cts_n[0] <= 1'b0;
    grab;
    check({20'h0, f}, {20'h0, frame(8'h5A, 5'h01)});
    foreach (modes[k]) begin
      seed = xs(seed);
      apb(12'h000, 1'b1, {27'h0, modes[k]}, 1'b0);
      apb(12'h008, 1'b1, {24'h0, seed[7:0]}, 1'b0);
      grab;
      check({20'h0, f}, {20'h0, frame(seed[7:0], modes[k])});
    end
    // parity on, hold off: a held rts would keep the polite peer waiting for ever
    apb(12'h010, 1'b1, 32'h3, 1'b0);
    for (int k = 0; k < 2; k++) begin
      seed = xs(seed);
      ufc_peer_i.send(seed[7:0], 1, k[0], 1'b0, BT);
      apb(12'h01C, 1'b0, 32'h0, 1'b0);
      check({18'h0, rd[13:0]}, {18'h0, 3'h4, 1'b0, k[0], 1'b1, seed[7:0]});
    end
    ufc_peer_i.send(8'h3C, 1, 1'b0, 1'b0, BT);
    repeat (2) @(posedge sys_clk);
    check({31'h0, uart_rts_n[1]}, 32'h1);
    ufc_peer_i.send(8'hC3, 1, 1'b0, 1'b1, BT);
    apb(12'h01C, 1'b0, 32'h0, 1'b0);
    check({20'h0, rd[11:0]}, {20'h0, 4'h9, 8'hC3});
    repeat (2) @(posedge sys_clk);
    check({31'h0, uart_rts_n[1]}, 32'h0);
    // software hold raises rts on its own and releasing it lowers rts again
    apb(12'h010, 1'b1, 32'h13, 1'b0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, uart_rts_n[1]}, 32'h1);
    apb(12'h010, 1'b1, 32'h3, 1'b0);
    repeat (2) @(posedge sys_clk);
    check({31'h0, uart_rts_n[1]}, 32'h0);
    apb(12'h000, 1'b1, 32'h3, 1'b0);
    seed = xs(seed);
    b = seed[7:0];
    apb(12'h018, 1'b1, {24'h0, b}, 1'b0);
    for (int t = 0; t < 300 && rd[ufc_pkg::ST_RXV] !== 1'b1; t++) apb(12'h00C, 1'b0, 32'h0, 1'b0);
    check({20'h0, rd[11:0]}, {20'h0, 4'h1, b});
    tally_and_finish;
  end
endmodule : test_uart_with_flow_control
